//--- hdl/fault_ctrl_defines.vh
// Register offsets, field positions, reset values and timing counts of the fault block
`ifndef FAULT_CTRL_DEFINES_VH
`define FAULT_CTRL_DEFINES_VH

// Register sub-addresses
`define ADDR_RESET_PIN_FAULT_MASK  8'h09
`define ADDR_INTERRUPT_MASK_FIRST  8'h0a
`define ADDR_INTERRUPT_MASK_SECOND 8'h0b
`define ADDR_POWER_GOOD_STATUS     8'h0c
`define ADDR_INPUT_LOCKOUT_STATUS  8'h0d
`define ADDR_THERMAL_STATUS        8'h0e
`define ADDR_GLOBAL_CONTROL        8'h0f

// Reset values
`define RESET_PIN_FAULT_MASK_INIT  8'hff
`define INTERRUPT_MASK_INIT        8'h00
`define GLOBAL_CONTROL_INIT        8'h00

// Global control field positions
`define GC_RESTART_BIT             7
`define GC_THRESH_HI               6
`define GC_THRESH_LO               5
`define GC_IGNORE_EN_BIT           4
`define GC_PULLDOWN_BIT            3
`define GC_SLOW_EDGE_BIT           2
`define GC_SAMPLE_BIT              1
`define GC_UNUSED_BIT              0

// Thermal status field positions
`define THERMAL_ALERT_BIT          7
`define TEMP_MSB                   6

// Overheat threshold select codes
`define THRESH_OFF                 2'b00
`define THRESH_140                 2'b01
`define THRESH_125                 2'b10
`define THRESH_110                 2'b11

// Conversion result codes that match each threshold
`define TEMP_CODE_140              7'h70
`define TEMP_CODE_125              7'h64
`define TEMP_CODE_110              7'h58

// Restart interval
`define RESTART_TIME_MS            1000
`define CLK_FREQ_KHZ               125000
// Product of the two above, sized to the 27-bit restart counter
`define RESTART_CYCLES             27'h773_5940

`endif

//--- hdl/restart_timer.v
// Timer that holds all converters off for the restart interval
`timescale 1ns/1ns
`include "fault_ctrl_defines.vh"

module restart_timer #(
  parameter [26:0] CYCLES = `RESTART_CYCLES
) (
  // Clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // Control
  input  wire        start,
  output reg         busy_q
);

  reg [26:0] count_q;

  // Busy lasts exactly CYCLES clocks; a start while busy is ignored
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q  <= 1'b0;
      count_q <= 27'h000_0000;
    end else if (!busy_q) begin
      if (start) begin
        busy_q  <= 1'b1;
        count_q <= CYCLES - 27'h000_0001;
      end
    end else if (count_q == 27'h000_0000) begin
      busy_q <= 1'b0; // Self clears, converters resume
    end else begin
      count_q <= count_q - 27'h000_0001;
    end
  end

endmodule // restart_timer

//--- hdl/temp_sampler.v
// Handshake with the temperature converter and capture of its result
`timescale 1ns/1ns
`include "fault_ctrl_defines.vh"

module temp_sampler (
  // Clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // Command side
  input  wire        start,
  output reg         busy_q,
  output reg         done_q,
  output reg  [6:0]  result_q,
  // Converter side
  output reg         adc_start_q,
  input  wire        adc_done,
  input  wire [6:0]  adc_result
);

  // Request held until the converter reports completion
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q      <= 1'b0;
      done_q      <= 1'b0;
      result_q    <= 7'h00;
      adc_start_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!busy_q) begin
        if (start) begin
          busy_q      <= 1'b1;
          adc_start_q <= 1'b1;
        end
      end else if (adc_done) begin
        busy_q      <= 1'b0;
        adc_start_q <= 1'b0;
        done_q      <= 1'b1;
        result_q    <= adc_result;
      end
    end
  end

endmodule // temp_sampler

//--- hdl/fault_mask_status_global_ctrl.v
// Fault masks, latched status, reset and interrupt outputs, global control register
//
// Function
// - Reset mask bit one lets matching power-good fault pull reset output low; resets ones.
// - Two interrupt masks at next two addresses, same layout, reset to zeros.
// - Power-good and lockout status registers, bit n-1 for regulator n, captured at interrupt.
// - Masked-off status bits read back the live, uncaptured fault condition.
// - Thermal status holds captured overheat alert on top, seven-bit temperature below.
// - Clear interrupt command wipes the captured status contents.
// - Power-good bit reads zero while output is too far below target.
// - Lockout bit reads zero with input above threshold, one below it.
// - Status registers are read only; writes to them change nothing.
// - Restart bit powers all converters down for one second, then self clears.
// - Two-bit overheat threshold select: off, 140, 125, 110 degrees; resets off.
// - Override bit zero lets enable pins start converters; one ignores the pins.
// - Pulldown bit ties shutdown switch nodes to ground through resistor; default floating.
// - Slew bit zero gives faster switch-node edges, one slower, for all converters.
// - Sample bit starts temperature conversion, clears itself when done, resets zero.
// - Every global control bit resets to zero.
`timescale 1ns/1ns
`include "fault_ctrl_defines.vh"

module fault_mask_status_global_ctrl #(
  parameter [26:0] RESTART_CYCLES = `RESTART_CYCLES
) (
  // Clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // Register access port, one sub-address per byte
  input  wire [7:0]  reg_addr,
  input  wire        reg_write,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_read,
  output reg  [7:0]  reg_rdata_q,
  output reg         reg_rvalid_q,
  // Clear interrupt command from the serial front end
  input  wire        clear_interrupt_command,
  // Analog fault comparators, bit n-1 for regulator n
  input  wire [7:0]  power_good_flag,
  input  wire [7:0]  input_lockout_flag,
  // Enable sources
  input  wire [7:0]  en_pin,
  input  wire [7:0]  program_enable,
  // Temperature converter
  output wire        adc_start_q,
  input  wire        adc_done,
  input  wire [6:0]  adc_result,
  // Fault outputs, active low
  output reg         reset_out_n_q,
  output reg         irq_n_q,
  // Converter controls
  output reg  [7:0]  converter_enable_q,
  output reg         switch_node_pulldown_q,
  output reg         switch_node_slow_edge_q,
  output reg  [1:0]  overheat_threshold_select_q,
  output reg         restart_active_q
);

  // Mask registers
  reg  [7:0] reset_pin_fault_mask_q;
  reg  [7:0] interrupt_mask_first_q;
  reg  [7:0] interrupt_mask_second_q;

  // Captured fault state, one means the fault was seen
  // Cleared only by the clear command, never by a read
  reg  [7:0] pg_fault_cap_q;
  reg  [7:0] lockout_fault_cap_q;
  reg        overheat_alert_q;

  // Stored global control fields
  // Unused bit 0 has no storage
  reg  [1:0] thresh_q;
  reg        ignore_en_q;
  reg        pulldown_q;
  reg        slow_edge_q;

  // Sub-block handshakes
  // Busy flags double as command readback
  wire       restart_busy;
  wire       sample_busy;
  wire       sample_done;
  wire [6:0] temp_result;
  wire       restart_start;
  wire       sample_start;

  // Decoded strobes and next values
  // Combinational; every flop sits further down
  wire       wr_reset_mask;
  wire       wr_mask_first;
  wire       wr_mask_second;
  wire       wr_global;
  wire [7:0] pg_fault_live;
  wire [7:0] lockout_fault_live;
  wire [7:0] pg_fault_set;
  wire [7:0] lockout_fault_set;
  wire       overheat_set;
  reg  [6:0] thresh_code;
  reg  [7:0] read_value;
  wire [7:0] global_readback;

  // Output summaries
  wire       reset_fault_any;
  wire       irq_cause_any;

  // Status view: enabled bits show the captured value, masked-off bits the live one
  // Read view, shared by both fault registers
  function [7:0] show_status;
    input [7:0] mask;
    input [7:0] live;
    input [7:0] captured;
    begin
      show_status = (mask & captured) | (~mask & live);
    end
  endfunction

  // Write strobe for one sub-address
  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // Write decode; status sub-addresses have no strobe at all
  // so a status write is simply dropped
  assign wr_reset_mask  = reg_write & hit(reg_addr, `ADDR_RESET_PIN_FAULT_MASK);
  assign wr_mask_first  = reg_write & hit(reg_addr, `ADDR_INTERRUPT_MASK_FIRST);
  assign wr_mask_second = reg_write & hit(reg_addr, `ADDR_INTERRUPT_MASK_SECOND);
  assign wr_global      = reg_write & hit(reg_addr, `ADDR_GLOBAL_CONTROL);

  // Self-clearing commands only launch; the sub-blocks own the busy state
  // Writing zero to a command bit has no effect
  assign restart_start  = wr_global & reg_wdata[`GC_RESTART_BIT];
  assign sample_start   = wr_global & reg_wdata[`GC_SAMPLE_BIT];

  // Mask registers
  // Reset mask starts all ones, irq masks zero
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_pin_fault_mask_q  <= `RESET_PIN_FAULT_MASK_INIT;
      interrupt_mask_first_q  <= `INTERRUPT_MASK_INIT;
      interrupt_mask_second_q <= `INTERRUPT_MASK_INIT;
    end else begin
      if (wr_reset_mask) begin
        reset_pin_fault_mask_q <= reg_wdata;
      end
      if (wr_mask_first) begin
        interrupt_mask_first_q <= reg_wdata;
      end
      if (wr_mask_second) begin
        interrupt_mask_second_q <= reg_wdata;
      end
    end
  end

  // Global control fields; the unused bit is never stored, so it reads zero
  // Command bits are busy flags in the sub-blocks
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      thresh_q    <= `THRESH_OFF;
      ignore_en_q <= 1'b0;
      pulldown_q  <= 1'b0;
      slow_edge_q <= 1'b0;
    end else if (wr_global) begin
      thresh_q    <= reg_wdata[`GC_THRESH_HI:`GC_THRESH_LO];
      ignore_en_q <= reg_wdata[`GC_IGNORE_EN_BIT];
      pulldown_q  <= reg_wdata[`GC_PULLDOWN_BIT];
      slow_edge_q <= reg_wdata[`GC_SLOW_EDGE_BIT];
    end
  end

  // Restart interval counter
  // A start while running is ignored
  restart_timer #(
    .CYCLES (RESTART_CYCLES)
  ) u_restart_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (restart_start),
    .busy_q  (restart_busy)
  );

  // Temperature conversion handshake
  // Result holds until the next conversion ends
  temp_sampler u_temp_sampler (
    .clk         (clk),
    .reset_n     (reset_n),
    .start       (sample_start),
    .busy_q      (sample_busy),
    .done_q      (sample_done),
    .result_q    (temp_result),
    .adc_start_q (adc_start_q),
    .adc_done    (adc_done),
    .adc_result  (adc_result)
  );

  // Live faults: power-good low means fault, lockout high means fault
  // Comparators taken as clean and synchronous
  assign pg_fault_live      = ~power_good_flag;
  assign lockout_fault_live = input_lockout_flag;

  // Only enabled faults are captured and raise the interrupt
  // Reset output uses its own mask instead
  assign pg_fault_set       = pg_fault_live & interrupt_mask_first_q;
  assign lockout_fault_set  = lockout_fault_live & interrupt_mask_second_q;

  // Threshold code for the selected overheat level
  // Code 00 is gated off at the compare
  always @* begin
    case (thresh_q)
      `THRESH_140: thresh_code = `TEMP_CODE_140;
      `THRESH_125: thresh_code = `TEMP_CODE_125;
      `THRESH_110: thresh_code = `TEMP_CODE_110;
      default:     thresh_code = 7'h7f;
    endcase
  end

  // Alert only on a finished conversion with the alert enabled
  // Old results never raise a second alert
  assign overheat_set = sample_done & (thresh_q != `THRESH_OFF) &
                        (temp_result >= thresh_code);

  // Captured status; a new fault in the clearing cycle survives the clear
  // so a fault seen during a clear is never lost
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pg_fault_cap_q      <= 8'h00;
      lockout_fault_cap_q <= 8'h00;
      overheat_alert_q    <= 1'b0;
    end else if (clear_interrupt_command) begin
      pg_fault_cap_q      <= pg_fault_set;
      lockout_fault_cap_q <= lockout_fault_set;
      overheat_alert_q    <= overheat_set;
    end else begin
      pg_fault_cap_q      <= pg_fault_cap_q | pg_fault_set;
      lockout_fault_cap_q <= lockout_fault_cap_q | lockout_fault_set;
      overheat_alert_q    <= overheat_alert_q | overheat_set;
    end
  end

  // Fault summaries behind the active-low outputs
  assign reset_fault_any = |(reset_pin_fault_mask_q & pg_fault_live);
  assign irq_cause_any   = (|pg_fault_cap_q) | (|lockout_fault_cap_q) |
                           overheat_alert_q;

  // Reset output follows live power-good faults through its own mask
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_out_n_q <= 1'b1;
    end else begin
      reset_out_n_q <= ~reset_fault_any;
    end
  end

  // Interrupt stays low until the captured faults are cleared
  // Clear only releases it once the fault is gone
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= ~irq_cause_any;
    end
  end

  // Converter enables; restart overrides every source
  // Program enables always count, so the host
  // can still sequence with pins ignored
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      converter_enable_q <= 8'h00;
    end else if (restart_busy) begin
      converter_enable_q <= 8'h00;
    end else if (ignore_en_q) begin
      converter_enable_q <= program_enable;
    end else begin
      converter_enable_q <= program_enable | en_pin;
    end
  end

  // Global analog controls, shared by every converter
  // One cycle later than the stored fields
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      switch_node_pulldown_q      <= 1'b0;
      switch_node_slow_edge_q     <= 1'b0;
      overheat_threshold_select_q <= `THRESH_OFF;
      restart_active_q            <= 1'b0;
    end else begin
      switch_node_pulldown_q      <= pulldown_q;
      switch_node_slow_edge_q     <= slow_edge_q;
      overheat_threshold_select_q <= thresh_q;
      restart_active_q            <= restart_busy;
    end
  end

  // Command bits read back as busy flags, so they appear to self clear
  // Bit 0 is the unused bit and reads zero
  assign global_readback = {restart_busy,
                            thresh_q,
                            ignore_en_q,
                            pulldown_q,
                            slow_edge_q,
                            sample_busy,
                            1'b0};

  // Read multiplexer; unmapped sub-addresses read zero
  always @* begin
    case (reg_addr)
      `ADDR_RESET_PIN_FAULT_MASK:  read_value = reset_pin_fault_mask_q;
      `ADDR_INTERRUPT_MASK_FIRST:  read_value = interrupt_mask_first_q;
      `ADDR_INTERRUPT_MASK_SECOND: read_value = interrupt_mask_second_q;
      `ADDR_POWER_GOOD_STATUS:
        read_value = show_status(interrupt_mask_first_q, power_good_flag,
                                 power_good_flag & ~pg_fault_cap_q);
      `ADDR_INPUT_LOCKOUT_STATUS:
        read_value = show_status(interrupt_mask_second_q, input_lockout_flag,
                                 input_lockout_flag | lockout_fault_cap_q);
      `ADDR_THERMAL_STATUS:
        read_value = {overheat_alert_q, temp_result};
      `ADDR_GLOBAL_CONTROL:        read_value = global_readback;
      default:                     read_value = 8'h00;
    endcase
  end

  // Read data registered one cycle after the strobe, no read side effects
  // Reading status never clears it
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q  <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_read;
      if (reg_read) begin
        reg_rdata_q <= read_value;
      end
    end
  end

endmodule // fault_mask_status_global_ctrl

//--- test/fault_ctrl_checker_sva.sv
// Concurrent checks on the fault mask, status and global control ports
`timescale 1ns/1ns

module fault_ctrl_checker #(
  parameter [26:0] RESTART_CYCLES = 27'h000_0014
) (
  // Clock and reset
  input wire       clk,
  input wire       reset_n,
  // Register port
  input wire       reg_read,
  input wire       reg_rvalid_q,
  // Fault and enable inputs
  input wire [7:0] power_good_flag,
  input wire [7:0] input_lockout_flag,
  input wire [7:0] en_pin,
  input wire [7:0] program_enable,
  // Temperature converter
  input wire       adc_start_q,
  input wire       adc_done,
  // Outputs
  input wire       reset_out_n_q,
  input wire       irq_n_q,
  input wire [7:0] converter_enable_q,
  input wire       restart_active_q
);
  reg [26:0] run_q;

  // Length of the current restart hold, checked when it ends
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      run_q <= 27'h000_0000;
    else if (restart_active_q)
      run_q <= run_q + 27'h000_0001;
    else
      run_q <= 27'h000_0000;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_conv_end;
    adc_start_q && adc_done;
  endsequence

  property p_read_answer;
    reg_read |=> reg_rvalid_q;
  endproperty
  property p_rst_cause;
    $fell(reset_out_n_q) |-> $past(power_good_flag) != 8'hff;
  endproperty
  property p_rst_live;
    (power_good_flag == 8'hff) |=> reset_out_n_q;
  endproperty
  // An overheat alert reaches the interrupt three edges after done
  property p_irq_cause;
    $fell(irq_n_q) |-> ($past(power_good_flag, 2) != 8'hff) ||
      ($past(input_lockout_flag, 2) != 8'h00) || $past(adc_done, 2) || $past(adc_done, 3);
  endproperty
  property p_restart_off;
    restart_active_q |-> converter_enable_q == 8'h00;
  endproperty
  property p_restart_len;
    $fell(restart_active_q) |-> run_q == RESTART_CYCLES;
  endproperty
  property p_sample_hold;
    adc_start_q && !adc_done |=> adc_start_q;
  endproperty
  property p_sample_end;
    s_conv_end |-> ##[1:2] !adc_start_q;
  endproperty
  // Either of the last two cycles may have supplied the enable
  property p_enable_src;
    (converter_enable_q & ~($past(program_enable) | $past(en_pin) |
      $past(program_enable, 2) | $past(en_pin, 2))) == 8'h00;
  endproperty

  a_read_answer: assert property (p_read_answer)
    else $error("read strobe without answer");
  a_rst_cause: assert property (p_rst_cause)
    else $error("reset output fell without fault");
  a_rst_live: assert property (p_rst_live)
    else $error("reset output low with all outputs good");
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt fell without cause");
  a_restart_off: assert property (p_restart_off)
    else $error("converter enabled during restart");
  a_restart_len: assert property (p_restart_len)
    else $error("restart hold has wrong length");
  a_sample_hold: assert property (p_sample_hold)
    else $error("conversion request dropped early");
  a_sample_end: assert property (p_sample_end)
    else $error("conversion request not released");
  a_enable_src: assert property (p_enable_src)
    else $error("converter enabled without source");
endmodule // fault_ctrl_checker

bind fault_mask_status_global_ctrl fault_ctrl_checker #(.RESTART_CYCLES(RESTART_CYCLES)) chk_u (
  .clk(clk), .reset_n(reset_n), .reg_read(reg_read), .reg_rvalid_q(reg_rvalid_q),
  .power_good_flag(power_good_flag), .input_lockout_flag(input_lockout_flag),
  .en_pin(en_pin), .program_enable(program_enable), .adc_start_q(adc_start_q),
  .adc_done(adc_done), .reset_out_n_q(reset_out_n_q), .irq_n_q(irq_n_q),
  .converter_enable_q(converter_enable_q), .restart_active_q(restart_active_q));

//--- test/temp_adc_model.sv
// Behavioural temperature converter answering conversion requests
`timescale 1ns/1ns

module temp_adc_model (
  // Clock and reset
  input  wire       clk,
  input  wire       reset_n,
  // Settings from the bench
  input  wire [3:0] delay,
  input  wire [6:0] value,
  // Converter side
  input  wire       adc_start,
  output reg        adc_done,
  output reg  [6:0] adc_result
);
  reg [3:0] wait_q;
  reg       run_q;
  reg       prev_q;

  // Start on a rising request only, so a request held past done is not re-run
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_q     <= 4'h0;
      run_q      <= 1'b0;
      prev_q     <= 1'b0;
      adc_done   <= 1'b0;
      adc_result <= 7'h00;
    end else begin
      prev_q     <= adc_start;
      adc_done   <= 1'b0;
      adc_result <= ~adc_result;  // Result only means something with done
      if (adc_start && !prev_q && !run_q) begin
        run_q  <= 1'b1;
        wait_q <= delay;
      end else if (run_q && wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (run_q) begin
        run_q      <= 1'b0;
        adc_done   <= 1'b1;
        adc_result <= value;
      end
    end
  end
endmodule // temp_adc_model

//--- test/fault_mask_status_global_ctrl_tb.sv
// Self-checking bench for the fault mask, status and global control block
`timescale 1ns/1ns

module fault_mask_status_global_ctrl_tb;
  reg        clk = 1'b0;
  reg        reset_n = 1'b0;
  reg  [7:0] reg_addr = 8'h00;
  reg        reg_write = 1'b0;
  reg  [7:0] reg_wdata = 8'h00;
  reg        reg_read = 1'b0;
  reg        clear_interrupt_command = 1'b0;
  reg  [7:0] power_good_flag = 8'hff;
  reg  [7:0] input_lockout_flag = 8'h00;
  reg  [7:0] en_pin = 8'h00;
  reg  [7:0] program_enable = 8'h00;
  wire [7:0] reg_rdata_q;
  wire [7:0] converter_enable_q;
  wire [6:0] adc_result;
  wire [1:0] overheat_threshold_select_q;
  wire       reg_rvalid_q, adc_start_q, adc_done, reset_out_n_q, irq_n_q;
  wire       switch_node_pulldown_q, switch_node_slow_edge_q, restart_active_q;
  integer    err_count = 0;
  integer    checked = 0;
  integer    i;

  // Short restart hold keeps the run brief
  fault_mask_status_global_ctrl #(.RESTART_CYCLES(27'h000_0014)) dut_u (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .clear_interrupt_command(clear_interrupt_command),
    .power_good_flag(power_good_flag), .input_lockout_flag(input_lockout_flag),
    .en_pin(en_pin), .program_enable(program_enable), .adc_start_q(adc_start_q),
    .adc_done(adc_done), .adc_result(adc_result), .reset_out_n_q(reset_out_n_q),
    .irq_n_q(irq_n_q), .converter_enable_q(converter_enable_q),
    .switch_node_pulldown_q(switch_node_pulldown_q),
    .switch_node_slow_edge_q(switch_node_slow_edge_q),
    .overheat_threshold_select_q(overheat_threshold_select_q),
    .restart_active_q(restart_active_q));

  temp_adc_model adc_u (
    .clk(clk), .reset_n(reset_n), .delay(4'h3), .value(7'h5a),
    .adc_start(adc_start_q), .adc_done(adc_done), .adc_result(adc_result));

  always #4 clk = ~clk;

  task finish_test;
    begin
      $display("Comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  task chk8(input [7:0] got, input [7:0] exp, input [8*20:1] what);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("CHECK FAILED at %0t: %0s got %h expected %h", $time, what, got, exp);
      end
    end
  endtask

  // Bounded waits end the run when they run out
  task need(input ok, input [8*20:1] what);
    begin
      if (ok !== 1'b1) begin
        err_count = err_count + 1;
        $display("CHECK FAILED at %0t: timeout on %0s", $time, what);
        finish_test;
      end
    end
  endtask

  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
    end
  endtask

  task rd(input [7:0] a, input [7:0] exp, input [8*20:1] what);
    integer n;
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      @(negedge clk);
      for (n = 0; n < 4 && reg_rvalid_q !== 1'b1; n = n + 1)
        @(negedge clk);
      need(reg_rvalid_q, "read answer");
      chk8(reg_rdata_q, exp, what);
    end
  endtask

  task clr;
    begin
      @(posedge clk);
      clear_interrupt_command <= 1'b1;
      @(posedge clk);
      clear_interrupt_command <= 1'b0;
    end
  endtask

  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    rd(8'h09, 8'hff, "reset mask init");
    rd(8'h0a, 8'h00, "irq mask 1 init");
    rd(8'h0b, 8'h00, "irq mask 2 init");
    rd(8'h0f, 8'h00, "global init");
    rd(8'h20, 8'h00, "unmapped read");
    $display("Reset value test done");
    wr(8'h09, 8'h5a);
    wr(8'h0a, 8'ha5);
    wr(8'h0b, 8'h3c);
    rd(8'h09, 8'h5a, "reset mask rw");
    rd(8'h0a, 8'ha5, "irq mask 1 rw");
    rd(8'h0b, 8'h3c, "irq mask 2 rw");
    for (i = 12; i < 15; i = i + 1)
      wr(i[7:0], 8'h55);
    rd(8'h0c, 8'hff, "pg status ro");
    rd(8'h0d, 8'h00, "lockout status ro");
    rd(8'h0e, 8'h00, "thermal status ro");
    $display("Access test done");
    // Regulator 3 unmasked for reset, masked in for interrupt
    wr(8'h09, 8'hfb);
    wr(8'h0a, 8'h04);
    wr(8'h0b, 8'h00);
    @(posedge clk);
    power_good_flag <= 8'hfb;
    repeat (3) @(negedge clk);
    chk8({7'h00, reset_out_n_q}, 8'h01, "reset mask off");
    chk8({7'h00, irq_n_q}, 8'h00, "irq on pg fault");
    rd(8'h0c, 8'hfb, "pg captured");
    @(posedge clk);
    power_good_flag <= 8'hdf;
    repeat (3) @(negedge clk);
    chk8({7'h00, reset_out_n_q}, 8'h00, "reset on pg fault");
    chk8({7'h00, irq_n_q}, 8'h00, "irq held");
    rd(8'h0c, 8'hdb, "pg latched and live");
    clr;
    repeat (3) @(negedge clk);
    chk8({7'h00, irq_n_q}, 8'h01, "irq after clear");
    rd(8'h0c, 8'hdf, "pg after clear");
    @(posedge clk);
    power_good_flag <= 8'hff;
    $display("Power-good test done");
    wr(8'h0b, 8'h01);
    @(posedge clk);
    input_lockout_flag <= 8'h81;
    repeat (3) @(negedge clk);
    chk8({7'h00, irq_n_q}, 8'h00, "irq on lockout");
    rd(8'h0d, 8'h81, "lockout live");
    @(posedge clk);
    input_lockout_flag <= 8'h00;
    rd(8'h0d, 8'h01, "lockout latched");
    clr;
    rd(8'h0d, 8'h00, "lockout cleared");
    $display("Lockout test done");
    // Every threshold code, pull-down and slew set opposite ways, unused bit zero
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h0f, {1'b0, i[1:0], 1'b0, i[0], ~i[0], 2'b00});
      repeat (2) @(negedge clk);
      chk8({6'h00, overheat_threshold_select_q}, i[7:0], "threshold field");
      chk8({6'h00, switch_node_pulldown_q, switch_node_slow_edge_q},
           {6'h00, i[0], ~i[0]}, "pulldown and slew");
      rd(8'h0f, {1'b0, i[1:0], 1'b0, i[0], ~i[0], 2'b00}, "global rw");
    end
    $display("Global field test done");
    wr(8'h0f, 8'h00);
    @(posedge clk);
    en_pin <= 8'h0f;
    program_enable <= 8'h30;
    repeat (3) @(negedge clk);
    chk8(converter_enable_q, 8'h3f, "pins enable");
    wr(8'h0f, 8'h10);
    repeat (3) @(negedge clk);
    chk8(converter_enable_q, 8'h30, "pins ignored");
    wr(8'h0f, 8'h00);
    $display("Enable test done");
    wr(8'h0f, 8'h80);
    rd(8'h0f, 8'h80, "restart busy");
    chk8(converter_enable_q, 8'h00, "restart powers down");
    for (i = 0; i < 100 && restart_active_q !== 1'b0; i = i + 1)
      @(negedge clk);
    need(!restart_active_q, "restart end");
    repeat (2) @(negedge clk);
    chk8(converter_enable_q, 8'h3f, "restart resumes");
    rd(8'h0f, 8'h00, "restart self clear");
    $display("Restart test done");
    wr(8'h0f, 8'h62);
    rd(8'h0f, 8'h62, "sample busy");
    for (i = 0; i < 40 && adc_start_q !== 1'b0; i = i + 1)
      @(negedge clk);
    need(!adc_start_q, "conversion end");
    rd(8'h0f, 8'h60, "sample self clear");
    rd(8'h0e, 8'hda, "thermal result");
    chk8({7'h00, irq_n_q}, 8'h00, "irq on overheat");
    $display("Temperature test done");
    finish_test;
  end
endmodule // fault_mask_status_global_ctrl_tb
